// [hw/arg_ramp.sv]
// Contract
// [R1] Enable rise: start/stop level held 100 ms
// [R2] Then ramp to chosen target at slope
// [R3] Halt: ramp down, hold 100 ms, zero
// [R4] No restart until halt and enable low
// [R5] Chooser change retargets ramp at slope
// [R6] Enable fall drops level to zero offset
// [R7] Level updates only every 100 ms tick
// [R8] Output is (level - zero) / gain; code computes (level - zero) * 100 / gain
// [R9] Targets may use live block values
// [R10] Chooser zero selects one, one two
// [R11] Level never exceeds level ceiling
// [R12] Slope is steps per second, 1..10000
// [R13] Output clamped to 0..32767
// [R14] Reset: idle, level zero, no latch
// [R15] Edges found against previous samples
`timescale 1ns/1ps
`default_nettype none
module arg_ramp #(
  parameter int TICK_CYCLES = arg_pkg::ARG_TICK_CYCLES
) (
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_reset_n,
  // AHB-Lite slave
  input wire logic i_hsel,
  input wire logic [31:0] i_haddr,
  input wire logic [1:0] i_htrans,
  input wire logic i_hwrite,
  input wire logic [2:0] i_hsize,
  input wire logic [31:0] i_hwdata,
  input wire logic i_hready,
  output logic o_hreadyout,
  output logic o_hresp,
  output logic [31:0] o_hrdata,
  // Digital inputs from pins
  input wire logic i_enable,
  input wire logic i_slow_halt_input,
  input wire logic i_target_chooser,
  // Live values of other function blocks
  input wire logic signed [15:0] i_target_one_live,
  input wire logic signed [15:0] i_target_two_live,
  // Results
  output logic signed [17:0] o_current_level,
  output logic [15:0] o_analog_output_value
);

  // Sign extension of a 16-bit parameter to level width
  function automatic logic signed [17:0] sx(input logic signed [15:0] v);
    sx = 18'(v);
  endfunction : sx

  // Move cur toward tgt by at most stp
  function automatic logic signed [17:0] toward(input logic signed [17:0] cur,
                                                input logic signed [17:0] tgt,
                                                input logic [10:0] stp);
    logic signed [18:0] up;
    logic signed [18:0] dn;
    up = 19'(cur) + 19'($signed({1'b0, stp}));
    dn = 19'(cur) - 19'($signed({1'b0, stp}));
    if (cur < tgt) begin
      toward = (up > 19'(tgt)) ? tgt : 18'(up);
    end else begin
      toward = (dn < 19'(tgt)) ? tgt : 18'(dn);
    end
  endfunction : toward

  // Registers
  logic [4:0] ctrl_q;
  logic signed [15:0] tone_q, ttwo_q, ceil_q, ss_q, zero_q;
  logic [13:0] slope_q;
  logic [9:0] gain_q;
  logic wr_pend_q;
  logic [7:0] wr_addr_q;
  logic [1:0] en_s_q, halt_s_q, sel_s_q;
  logic en_prev_q, halt_prev_q;
  logic [23:0] tick_cnt_q;
  logic [3:0] rem_q;
  logic [1:0] hold_q;
  arg_pkg::arg_state_t state_q, state_d;
  logic signed [17:0] level_q, level_d;
  logic [1:0] hold_d;

  // Bus decode
  wire bus_take = i_hsel & i_hready & i_htrans[1];
  wire [7:0] bus_addr = {i_haddr[7:2], 2'b00};
  wire addr_in_map = (i_haddr[31:8] == 24'h000000);
  wire wr_ctrl = wr_pend_q & (wr_addr_q == arg_pkg::ARG_CTRL_OFS);

  // Combined control inputs: pin or software bit
  wire en_now = en_s_q[1] | ctrl_q[arg_pkg::ARG_CTRL_ENABLE_BIT];
  wire halt_now = halt_s_q[1] | ctrl_q[arg_pkg::ARG_CTRL_HALT_BIT];
  wire chooser = sel_s_q[1] | ctrl_q[arg_pkg::ARG_CTRL_CHOOSER_BIT];
  wire en_rise = en_now & ~en_prev_q; // [R15]
  wire en_fall = ~en_now & en_prev_q; // [R15]
  wire halt_rise = halt_now & ~halt_prev_q; // [R15]

  // Target selection and levels
  wire signed [15:0] t1 = ctrl_q[arg_pkg::ARG_CTRL_ONE_LIVE_BIT] ? i_target_one_live : tone_q; // [R9]
  wire signed [15:0] t2 = ctrl_q[arg_pkg::ARG_CTRL_TWO_LIVE_BIT] ? i_target_two_live : ttwo_q; // [R9]
  wire signed [17:0] tsel = chooser ? sx(t2) : sx(t1); // [R10] [R5]
  wire signed [17:0] zero_lvl = sx(zero_q);
  wire signed [17:0] ss_lvl = sx(ss_q) + sx(zero_q);
  wire signed [17:0] ceil_lvl = sx(ceil_q);
  wire signed [17:0] tgt_run = (tsel > ceil_lvl) ? ceil_lvl : tsel; // [R11]
  wire signed [17:0] ss_stop = (ss_lvl > ceil_lvl) ? ceil_lvl : ss_lvl; // [R11]

  // Update tick and slope steps per tick
  wire tick = (tick_cnt_q == 24'(TICK_CYCLES - 1)); // [R7]
  wire [13:0] slope_c = (slope_q < arg_pkg::ARG_SLOPE_MIN) ? arg_pkg::ARG_SLOPE_MIN :
                        (slope_q > arg_pkg::ARG_SLOPE_MAX) ? arg_pkg::ARG_SLOPE_MAX : slope_q;
  wire [14:0] acc = 15'(slope_c) + 15'(rem_q); // [R12]
  wire [10:0] step = 11'(acc / arg_pkg::ARG_TICKS_PER_SEC); // [R12]
  wire [3:0] rem_d = 4'(acc % arg_pkg::ARG_TICKS_PER_SEC);

  // Ramp state machine
  always_comb begin
    state_d = state_q;
    level_d = level_q;
    hold_d = hold_q;
    if (en_fall) begin
      level_d = zero_lvl; // [R6]
      state_d = halt_now ? arg_pkg::ARG_LOCKED : arg_pkg::ARG_IDLE;
    end else begin
      case (state_q)
        arg_pkg::ARG_IDLE: begin
          if (en_rise && !halt_now) begin
            level_d = ss_lvl; // [R1]
            hold_d = arg_pkg::ARG_HOLD_TICKS;
            state_d = arg_pkg::ARG_HOLD_START;
          end
        end
        arg_pkg::ARG_HOLD_START: begin
          if (halt_rise) begin
            state_d = arg_pkg::ARG_RAMP_DOWN;
          end else if (tick) begin
            hold_d = hold_q - 2'd1;
            if (hold_q == 2'd1) begin
              state_d = arg_pkg::ARG_RUN; // [R1]
            end
          end
        end
        arg_pkg::ARG_RUN: begin
          if (halt_rise) begin
            state_d = arg_pkg::ARG_RAMP_DOWN; // [R3]
          end else if (tick) begin
            level_d = toward(level_q, tgt_run, step); // [R2] [R5] [R7]
          end
        end
        arg_pkg::ARG_RAMP_DOWN: begin
          if (tick) begin
            level_d = toward(level_q, ss_stop, step); // [R3] [R7]
            if (level_d == ss_stop) begin
              hold_d = arg_pkg::ARG_HOLD_TICKS;
              state_d = arg_pkg::ARG_HOLD_STOP;
            end
          end
        end
        arg_pkg::ARG_HOLD_STOP: begin
          if (tick) begin
            hold_d = hold_q - 2'd1;
            if (hold_q == 2'd1) begin
              level_d = zero_lvl; // [R3]
              state_d = arg_pkg::ARG_LOCKED;
            end
          end
        end
        arg_pkg::ARG_LOCKED: begin
          if (!halt_now && !en_now) begin
            state_d = arg_pkg::ARG_IDLE; // [R4]
          end
        end
        default: begin
          state_d = arg_pkg::ARG_IDLE;
        end
      endcase
    end
    if (level_d > ceil_lvl) begin
      level_d = ceil_lvl; // [R11]
    end
  end

  // Output scaling and clamp
  wire signed [31:0] diff = 32'(level_q) - 32'(zero_lvl); // [R8]
  wire signed [31:0] scaled = diff * $signed(arg_pkg::ARG_GAIN_UNIT);
  wire signed [31:0] quot = (gain_q == 10'h000) ? $signed(arg_pkg::ARG_OUT_MAX) :
                            scaled / $signed({22'h000000, gain_q}); // [R8]
  wire [15:0] out_d = (diff <= 32'sd0) ? 16'h0000 :
                      (quot > $signed(arg_pkg::ARG_OUT_MAX)) ? 16'h7FFF : 16'(quot); // [R13]

  // Read mux
  wire [31:0] rd_mux =
    (bus_addr == arg_pkg::ARG_CTRL_OFS) ? {27'h0, ctrl_q} :
    (bus_addr == arg_pkg::ARG_TARGET_ONE_OFS) ? 32'(tone_q) :
    (bus_addr == arg_pkg::ARG_TARGET_TWO_OFS) ? 32'(ttwo_q) :
    (bus_addr == arg_pkg::ARG_CEILING_OFS) ? 32'(ceil_q) :
    (bus_addr == arg_pkg::ARG_START_STOP_OFS) ? 32'(ss_q) :
    (bus_addr == arg_pkg::ARG_SLOPE_OFS) ? {18'h0, slope_q} :
    (bus_addr == arg_pkg::ARG_ZERO_OFS) ? 32'(zero_q) :
    (bus_addr == arg_pkg::ARG_GAIN_OFS) ? {22'h0, gain_q} :
    (bus_addr == arg_pkg::ARG_LEVEL_OFS) ? 32'(level_q) :
    (bus_addr == arg_pkg::ARG_OUTPUT_OFS) ? {16'h0, o_analog_output_value} :
    (bus_addr == arg_pkg::ARG_STATUS_OFS) ? {29'h0, state_q} : 32'h0000_0000;

  assign o_hreadyout = 1'b1;
  assign o_hresp = 1'b0;
  assign o_current_level = level_q;

  // Bus address phase capture and read data
  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= 8'h00;
      o_hrdata <= 32'h0000_0000;
    end else begin
      wr_pend_q <= bus_take & i_hwrite & addr_in_map;
      wr_addr_q <= bus_addr;
      if (bus_take && !i_hwrite) begin
        o_hrdata <= addr_in_map ? rd_mux : 32'h0000_0000;
      end
    end
  end

  // Register writes in the data phase
  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      ctrl_q <= arg_pkg::ARG_CTRL_RST;
      tone_q <= arg_pkg::ARG_TARGET_RST;
      ttwo_q <= arg_pkg::ARG_TARGET_RST;
      ceil_q <= arg_pkg::ARG_CEILING_RST;
      ss_q <= arg_pkg::ARG_START_STOP_RST;
      slope_q <= arg_pkg::ARG_SLOPE_RST;
      zero_q <= arg_pkg::ARG_ZERO_RST;
      gain_q <= arg_pkg::ARG_GAIN_RST;
    end else if (wr_pend_q) begin
      if (wr_ctrl) ctrl_q <= i_hwdata[4:0];
      if (wr_addr_q == arg_pkg::ARG_TARGET_ONE_OFS) tone_q <= i_hwdata[15:0];
      if (wr_addr_q == arg_pkg::ARG_TARGET_TWO_OFS) ttwo_q <= i_hwdata[15:0];
      if (wr_addr_q == arg_pkg::ARG_CEILING_OFS) ceil_q <= i_hwdata[15:0];
      if (wr_addr_q == arg_pkg::ARG_START_STOP_OFS) ss_q <= i_hwdata[15:0];
      if (wr_addr_q == arg_pkg::ARG_SLOPE_OFS) slope_q <= i_hwdata[13:0];
      if (wr_addr_q == arg_pkg::ARG_ZERO_OFS) zero_q <= i_hwdata[15:0];
      if (wr_addr_q == arg_pkg::ARG_GAIN_OFS) gain_q <= i_hwdata[9:0];
    end
  end

  // Pin synchronisers and edge history
  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      en_s_q <= 2'h0;
      halt_s_q <= 2'h0;
      sel_s_q <= 2'h0;
      en_prev_q <= 1'b0;
      halt_prev_q <= 1'b0;
    end else begin
      en_s_q <= {en_s_q[0], i_enable};
      halt_s_q <= {halt_s_q[0], i_slow_halt_input};
      sel_s_q <= {sel_s_q[0], i_target_chooser};
      en_prev_q <= en_now; // [R15]
      halt_prev_q <= halt_now; // [R15]
    end
  end

  // Update tick, restarted on enable so holds last one full interval
  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      tick_cnt_q <= 24'h000000;
      rem_q <= 4'h0;
    end else begin
      tick_cnt_q <= (tick || en_rise) ? 24'h000000 : tick_cnt_q + 24'h000001; // [R7]
      if (tick) rem_q <= rem_d;
    end
  end

  // Ramp state and outputs
  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      state_q <= arg_pkg::ARG_IDLE; // [R14]
      level_q <= 18'sh00000; // [R14]
      hold_q <= 2'h0;
      o_analog_output_value <= 16'h0000;
    end else begin
      state_q <= state_d;
      level_q <= level_d;
      hold_q <= hold_d;
      o_analog_output_value <= out_d;
    end
  end

endmodule : arg_ramp
`default_nettype wire

// [hw/arg_pkg.sv]
package arg_pkg;

  // Register byte offsets
  localparam logic [7:0] ARG_CTRL_OFS = 8'h00;
  localparam logic [7:0] ARG_TARGET_ONE_OFS = 8'h04;
  localparam logic [7:0] ARG_TARGET_TWO_OFS = 8'h08;
  localparam logic [7:0] ARG_CEILING_OFS = 8'h0C;
  localparam logic [7:0] ARG_START_STOP_OFS = 8'h10;
  localparam logic [7:0] ARG_SLOPE_OFS = 8'h14;
  localparam logic [7:0] ARG_ZERO_OFS = 8'h18;
  localparam logic [7:0] ARG_GAIN_OFS = 8'h1C;
  localparam logic [7:0] ARG_LEVEL_OFS = 8'h20;
  localparam logic [7:0] ARG_OUTPUT_OFS = 8'h24;
  localparam logic [7:0] ARG_STATUS_OFS = 8'h28;

  // Control register bit positions
  localparam int ARG_CTRL_ENABLE_BIT = 0;
  localparam int ARG_CTRL_HALT_BIT = 1;
  localparam int ARG_CTRL_CHOOSER_BIT = 2;
  localparam int ARG_CTRL_ONE_LIVE_BIT = 3;
  localparam int ARG_CTRL_TWO_LIVE_BIT = 4;

  // Reset values
  localparam logic [4:0] ARG_CTRL_RST = 5'h00;
  localparam logic signed [15:0] ARG_TARGET_RST = 16'sh0000;
  localparam logic signed [15:0] ARG_CEILING_RST = 16'sh4E20;
  localparam logic signed [15:0] ARG_START_STOP_RST = 16'sh0000;
  localparam logic [13:0] ARG_SLOPE_RST = 14'h000A;
  localparam logic signed [15:0] ARG_ZERO_RST = 16'sh0000;
  localparam logic [9:0] ARG_GAIN_RST = 10'h064;

  // Limits and scaling
  localparam logic [13:0] ARG_SLOPE_MIN = 14'h0001;
  localparam logic [13:0] ARG_SLOPE_MAX = 14'h2710;
  localparam logic [31:0] ARG_OUT_MAX = 32'h0000_7FFF;
  localparam logic [31:0] ARG_GAIN_UNIT = 32'h0000_0064;
  localparam logic [14:0] ARG_TICKS_PER_SEC = 15'h000A;

  // Timing: update interval and hold lengths
  localparam int ARG_TICK_MS = 100;
  localparam int ARG_CLK_KHZ = 125000;
  localparam int ARG_TICK_CYCLES = ARG_TICK_MS * ARG_CLK_KHZ;
  localparam int ARG_HOLD_MS = 100;
  localparam logic [1:0] ARG_HOLD_TICKS = 2'(ARG_HOLD_MS / ARG_TICK_MS);

  typedef enum logic [2:0] {
    ARG_IDLE,
    ARG_HOLD_START,
    ARG_RUN,
    ARG_RAMP_DOWN,
    ARG_HOLD_STOP,
    ARG_LOCKED
  } arg_state_t;

endpackage : arg_pkg

// [verification/arg_ramp_properties.sv]
`timescale 1ns/1ps
`default_nettype none
module arg_ramp_properties #(
  parameter int TICK_CYCLES = arg_pkg::ARG_TICK_CYCLES
) (
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_reset_n,
  // Bus
  input wire logic i_hsel,
  input wire logic [31:0] i_haddr,
  input wire logic [1:0] i_htrans,
  input wire logic i_hwrite,
  input wire logic [2:0] i_hsize,
  input wire logic [31:0] i_hwdata,
  input wire logic i_hready,
  input wire logic o_hreadyout,
  input wire logic o_hresp,
  input wire logic [31:0] o_hrdata,
  // Pins and results
  input wire logic i_enable,
  input wire logic i_slow_halt_input,
  input wire logic i_target_chooser,
  input wire logic signed [15:0] i_target_one_live,
  input wire logic signed [15:0] i_target_two_live,
  input wire logic signed [17:0] o_current_level,
  input wire logic [15:0] o_analog_output_value
);
  logic [7:0] a_q;
  logic w_q;
  logic en_q;
  logic en_p;
  logic en;
  logic signed [17:0] zero_q, ceil_q, lvl_q;
  logic [9:0] gain_q;
  int wr_cnt, ec, chg_cnt;
  logic signed [18:0] diff;
  logic [31:0] scaled, exp_out;
  // Expected scaled output from the snooped settings
  assign en = i_enable | en_q;
  assign diff = o_current_level - zero_q;
  assign scaled = 32'(diff) * 32'h64 / 32'(gain_q);
  assign exp_out = diff <= 0 ? 32'h0 : (gain_q == 0 || scaled > 32'h7FFF) ? 32'h7FFF : scaled;
  // Snoop writes and count spacing between events
  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      a_q <= 8'h00;
      w_q <= 1'b0;
      en_q <= 1'b0;
      en_p <= 1'b0;
      zero_q <= 18'sh00000;
      ceil_q <= 18'sh04E20;
      gain_q <= 10'h064;
      lvl_q <= 18'sh00000;
      wr_cnt <= 0;
      ec <= 0;
      chg_cnt <= 0;
    end else begin
      a_q <= i_haddr[7:0];
      w_q <= i_hsel & i_hready & i_htrans[1] & i_hwrite & (i_haddr[31:8] == 24'h0);
      en_p <= en;
      lvl_q <= o_current_level;
      wr_cnt <= w_q ? 0 : wr_cnt + 32'(wr_cnt < 999);
      ec <= (en != en_p) ? 0 : ec + 32'(ec < 99);
      chg_cnt <= (o_current_level != lvl_q) ? 0 : chg_cnt + 32'(chg_cnt < 999);
      if (w_q && a_q == arg_pkg::ARG_CTRL_OFS) en_q <= i_hwdata[0];
      if (w_q && a_q == arg_pkg::ARG_ZERO_OFS) zero_q <= 18'($signed(i_hwdata[15:0]));
      if (w_q && a_q == arg_pkg::ARG_CEILING_OFS) ceil_q <= 18'($signed(i_hwdata[15:0]));
      if (w_q && a_q == arg_pkg::ARG_GAIN_OFS) gain_q <= i_hwdata[9:0];
    end
  end
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_reset_n);
  a_bus_okay: assert property (o_hreadyout && !o_hresp)
    else $error("bus stalled or answered with an error");
  a_output_range: assert property (o_analog_output_value <= 16'h7FFF)
    else $error("output above its top value");
  a_output_scaled: assert property (wr_cnt > 2 |=> o_analog_output_value == $past(exp_out[15:0]))
    else $error("output does not follow the level");
  a_disable_zero: assert property (!en && ec == 5 |-> o_current_level == zero_q)
    else $error("level not at zero offset after disable");
  a_step_spacing: assert property ($changed(o_current_level) && en && ec > 8 && wr_cnt > TICK_CYCLES |-> chg_cnt >= TICK_CYCLES - 1)
    else $error("level moved between update ticks");
  a_ceiling_kept: assert property (wr_cnt > 2 |-> o_current_level <= ceil_q)
    else $error("level above its ceiling");
  a_reset_idle: assert property ($rose(i_reset_n) |-> o_current_level == 18'sh0 && o_analog_output_value == 16'h0)
    else $error("level or output not cleared by reset");
  a_unmapped_zero: assert property (i_hsel && i_hready && i_htrans[1] && !i_hwrite && i_haddr[31:8] != 24'h0 |=> o_hrdata == 32'h0)
    else $error("unmapped read returned data");
endmodule : arg_ramp_properties
`default_nettype wire

// [verification/arg_far_side.sv]
`timescale 1ns/1ps
`default_nettype none
module arg_far_side (
  // Clock
  input wire logic i_ref_clk,
  // Pins and live block values
  output logic o_enable,
  output logic o_slow_halt_input,
  output logic o_target_chooser,
  output logic signed [15:0] o_target_one_live,
  output logic signed [15:0] o_target_two_live
);
  // Digital pins, changed just after an edge
  task pins(input logic e, input logic h, input logic s);
    @(posedge i_ref_clk);
    o_enable <= e;
    o_slow_halt_input <= h;
    o_target_chooser <= s;
  endtask : pins
  // Actual values of other blocks, seen live by the ramp
  task live(input logic signed [15:0] a, input logic signed [15:0] b);
    o_target_one_live <= a;
    o_target_two_live <= b;
  endtask : live
  initial pins(1'b0, 1'b0, 1'b0);
  initial live(16'sh0000, 16'sh0000);
endmodule : arg_far_side
`default_nettype wire

// [verification/arg_ramp_test.sv]
`timescale 1ns/1ps
`default_nettype none
module arg_ramp_test;
  logic i_ref_clk = 1'b0;
  logic i_reset_n = 1'b0;
  logic i_hsel = 1'b0;
  logic [31:0] i_haddr = 32'h0;
  logic [31:0] i_hwdata = 32'h0;
  logic [1:0] i_htrans = 2'h0;
  logic i_hwrite = 1'b0;
  logic [31:0] rv;
  wire logic o_hreadyout, o_hresp, en, halt, sel;
  wire logic [31:0] o_hrdata;
  wire logic signed [15:0] l1, l2;
  int failures = 0;
  int check_count = 0;
  // Clock at 125 MHz
  always #4 i_ref_clk = ~i_ref_clk;
  arg_ramp #(.TICK_CYCLES(20)) arg_ramp_i (.i_ref_clk(i_ref_clk), .i_reset_n(i_reset_n),
    .i_hsel(i_hsel), .i_haddr(i_haddr), .i_htrans(i_htrans), .i_hwrite(i_hwrite), .i_hsize(3'h2),
    .i_hwdata(i_hwdata), .i_hready(o_hreadyout), .o_hreadyout(o_hreadyout), .o_hresp(o_hresp),
    .o_hrdata(o_hrdata), .i_enable(en), .i_slow_halt_input(halt), .i_target_chooser(sel),
    .i_target_one_live(l1), .i_target_two_live(l2), .o_current_level(), .o_analog_output_value());
  arg_far_side arg_far_side_i (.i_ref_clk(i_ref_clk), .o_enable(en), .o_slow_halt_input(halt),
    .o_target_chooser(sel), .o_target_one_live(l1), .o_target_two_live(l2));
  // One bus transfer: address phase, then data phase
  task xfer(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge i_ref_clk);
    i_hsel <= 1'b1;
    i_haddr <= a;
    i_htrans <= 2'h2;
    i_hwrite <= w;
    do @(posedge i_ref_clk); while (o_hreadyout !== 1'b1);
    i_hsel <= 1'b0;
    i_htrans <= 2'h0;
    i_hwdata <= d;
    do @(posedge i_ref_clk); while (o_hreadyout !== 1'b1);
    rv = o_hrdata;
  endtask : xfer
  task wr(input logic [31:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask : wr
  // Read until the value shows or the tries run out
  task poll(input logic [31:0] a, input logic [31:0] exp, input int n);
    for (int i = 0; i < n; i++) begin
      xfer(1'b0, a, 32'h0);
      if (rv === exp) break;
    end
    check_count++;
    if (rv !== exp) begin
      $display("unexpected at %0t: read %h, expected %h", $time, rv, exp);
      failures++;
    end
  endtask : poll
  task end_of_test;
    $display("checks %0d, failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : end_of_test
  // Watchdog
  initial begin
    repeat (20000) @(posedge i_ref_clk);
    failures++;
    end_of_test();
  end
  // Main sequence
  initial begin
    repeat (10) @(posedge i_ref_clk);
    i_reset_n <= 1'b1;
    poll(arg_pkg::ARG_CTRL_OFS, 32'h0, 1);
    poll(arg_pkg::ARG_CEILING_OFS, 32'h4E20, 1);
    poll(arg_pkg::ARG_SLOPE_OFS, 32'hA, 1);
    poll(arg_pkg::ARG_GAIN_OFS, 32'h64, 1);
    poll(32'h100, 32'h0, 1);
    wr(arg_pkg::ARG_START_STOP_OFS, 32'h32);
    wr(arg_pkg::ARG_TARGET_ONE_OFS, 32'h64);
    wr(arg_pkg::ARG_SLOPE_OFS, 32'h64);
    arg_far_side_i.pins(1'b1, 1'b0, 1'b0);
    poll(arg_pkg::ARG_STATUS_OFS, 32'h1, 20);
    poll(arg_pkg::ARG_LEVEL_OFS, 32'h32, 1);
    poll(arg_pkg::ARG_STATUS_OFS, 32'h2, 20);
    poll(arg_pkg::ARG_LEVEL_OFS, 32'h64, 60);
    arg_far_side_i.live(16'sh0000, 16'sh0046);
    wr(arg_pkg::ARG_CTRL_OFS, 32'h10);
    arg_far_side_i.pins(1'b1, 1'b0, 1'b1);
    poll(arg_pkg::ARG_LEVEL_OFS, 32'h46, 60);
    arg_far_side_i.pins(1'b1, 1'b0, 1'b0);
    poll(arg_pkg::ARG_LEVEL_OFS, 32'h64, 60);
    wr(arg_pkg::ARG_CEILING_OFS, 32'h5A);
    poll(arg_pkg::ARG_LEVEL_OFS, 32'h5A, 10);
    wr(arg_pkg::ARG_CEILING_OFS, 32'h4E20);
    arg_far_side_i.pins(1'b1, 1'b1, 1'b0);
    poll(arg_pkg::ARG_STATUS_OFS, 32'h4, 60);
    poll(arg_pkg::ARG_LEVEL_OFS, 32'h32, 1);
    poll(arg_pkg::ARG_STATUS_OFS, 32'h5, 20);
    poll(arg_pkg::ARG_LEVEL_OFS, 32'h0, 1);
    arg_far_side_i.pins(1'b0, 1'b1, 1'b0);
    arg_far_side_i.pins(1'b1, 1'b0, 1'b0);
    repeat (6) @(posedge i_ref_clk);
    poll(arg_pkg::ARG_STATUS_OFS, 32'h5, 1);
    poll(arg_pkg::ARG_LEVEL_OFS, 32'h0, 1);
    arg_far_side_i.pins(1'b0, 1'b0, 1'b0);
    poll(arg_pkg::ARG_STATUS_OFS, 32'h0, 5);
    wr(arg_pkg::ARG_ZERO_OFS, 32'h5);
    wr(arg_pkg::ARG_GAIN_OFS, 32'hC8);
    arg_far_side_i.pins(1'b1, 1'b0, 1'b0);
    poll(arg_pkg::ARG_STATUS_OFS, 32'h1, 20);
    poll(arg_pkg::ARG_LEVEL_OFS, 32'h37, 1);
    poll(arg_pkg::ARG_OUTPUT_OFS, 32'h19, 1);
    wr(arg_pkg::ARG_GAIN_OFS, 32'h0);
    poll(arg_pkg::ARG_OUTPUT_OFS, 32'h7FFF, 2);
    arg_far_side_i.pins(1'b0, 1'b0, 1'b0);
    repeat (6) @(posedge i_ref_clk);
    poll(arg_pkg::ARG_LEVEL_OFS, 32'h5, 1);
    // Software control bits, slope clamp and live targets
    wr(arg_pkg::ARG_GAIN_OFS, 32'h64);
    wr(arg_pkg::ARG_SLOPE_OFS, 32'h3FFF);
    wr(arg_pkg::ARG_TARGET_ONE_OFS, 32'h7D0);
    wr(arg_pkg::ARG_CTRL_OFS, 32'h1);
    poll(arg_pkg::ARG_STATUS_OFS, 32'h2, 20);
    poll(arg_pkg::ARG_LEVEL_OFS, 32'h41F, 20);
    poll(arg_pkg::ARG_LEVEL_OFS, 32'h7D0, 20);
    arg_far_side_i.live(16'sh0100, 16'sh0046);
    wr(arg_pkg::ARG_CTRL_OFS, 32'h9);
    poll(arg_pkg::ARG_LEVEL_OFS, 32'h100, 30);
    arg_far_side_i.live(16'sh0200, 16'sh0046);
    poll(arg_pkg::ARG_LEVEL_OFS, 32'h200, 30);
    wr(arg_pkg::ARG_CTRL_OFS, 32'hD);
    poll(arg_pkg::ARG_LEVEL_OFS, 32'h0, 30);
    wr(arg_pkg::ARG_CTRL_OFS, 32'hF);
    poll(arg_pkg::ARG_STATUS_OFS, 32'h5, 40);
    poll(arg_pkg::ARG_LEVEL_OFS, 32'h5, 1);
    wr(arg_pkg::ARG_CTRL_OFS, 32'h1);
    repeat (6) @(posedge i_ref_clk);
    poll(arg_pkg::ARG_STATUS_OFS, 32'h5, 1);
    wr(arg_pkg::ARG_CTRL_OFS, 32'h0);
    poll(arg_pkg::ARG_STATUS_OFS, 32'h0, 5);
    wr(arg_pkg::ARG_CTRL_OFS, 32'h2);
    wr(arg_pkg::ARG_CTRL_OFS, 32'h3);
    repeat (6) @(posedge i_ref_clk);
    poll(arg_pkg::ARG_STATUS_OFS, 32'h0, 1);
    poll(arg_pkg::ARG_LEVEL_OFS, 32'h5, 1);
    end_of_test();
  end
endmodule : arg_ramp_test
bind arg_ramp arg_ramp_properties #(.TICK_CYCLES(TICK_CYCLES)) arg_ramp_properties_i (
  .i_ref_clk(i_ref_clk), .i_reset_n(i_reset_n), .i_hsel(i_hsel), .i_haddr(i_haddr),
  .i_htrans(i_htrans), .i_hwrite(i_hwrite), .i_hsize(i_hsize), .i_hwdata(i_hwdata),
  .i_hready(i_hready), .o_hreadyout(o_hreadyout), .o_hresp(o_hresp), .o_hrdata(o_hrdata),
  .i_enable(i_enable), .i_slow_halt_input(i_slow_halt_input), .i_target_chooser(i_target_chooser),
  .i_target_one_live(i_target_one_live), .i_target_two_live(i_target_two_live),
  .o_current_level(o_current_level), .o_analog_output_value(o_analog_output_value));
`default_nettype wire
